// ---- design/tmrctr_ripple.sv ----
// Ripple prescaler for the counter input, clocked by the raw external edge.
// Assumes the clear input is a level or pulse that is safe to apply at any time.
`timescale 1ns/1ps
`default_nettype none

module tmrctr_ripple
    import tmrctr_pkg::*;
#(
    parameter int STAGES = 3
) (
    // Raw input and clear
    input  wire logic             i_raw,
    input  wire logic             i_clr,
    // Ratio select and divided output
    input  wire tmrctr_prescale_e i_sel,
    output logic                  o_div
);

    logic [STAGES-1:0] q;
    logic [STAGES:0]   tick;

    assign tick[0] = i_raw;

    // ------------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------------
    // Stage 0 toggles on each raw rise, each later stage on the fall of the one
    // before, so stage n rises once per 2^(n+1) raw rising edges. No core clock is needed, so it keeps running
    // while the core sleeps.
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            always_ff @(posedge tick[g] or posedge i_clr) begin
                if (i_clr) begin
                    q[g] <= 1'b0;
                end else begin
                    q[g] <= ~q[g];
                end
            end
            assign tick[g+1] = ~q[g];
        end
    endgenerate

    always_comb begin
        case (i_sel)
            TMRCTR_DIV1: o_div = i_raw;
            TMRCTR_DIV2: o_div = q[0];
            TMRCTR_DIV4: o_div = q[1];
            TMRCTR_DIV8: o_div = q[2];
            default:     o_div = i_raw;
        endcase
    end

endmodule

`default_nettype wire

// ---- design/tmrctr_top.sv ----
// Top of the 16-bit timer/counter with byte registers, pin control and
// compare-unit clear.
// Assumes one core clock; the pins and the prescaler output are asynchronous.
//
// Operation
// - Count upward 0000h to FFFFh, then wrap.
// - Wrap latches flag; interrupt only when enabled.
// - Control bit 1 picks external or internal.
// - Control bit 0 runs; clear holds count.
// - Bits 5-4 divide by 1, 2, 4, 8.
// - Oscillator enable forces pins input, reads zero.
// - Counter edges from oscillator or clock pin.
// - Bit 2 picks unsynchronized mode, only counter mode.
// - Ripple prescaler on raw input, sync after.
// - Synchronized mode halts count during sleep.
// - Unsynchronized mode counts in sleep, wakes.
// - Unsynchronized mode gives compare units no timebase.
// - Count byte reads always return valid values.
// - Compare special event clears count to zero.
// - Special event clear never sets overflow flag.
// - Special clear honoured only in synchronized modes.
// - Count write beats same-cycle special clear.
// - No reset touches the count bytes.
// - Power-on reset clears control register.
// - Control bits 7-6 read zero, ignore writes.
// - Count byte write clears prescaler count.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tmrctr_regs.svh"

module tmrctr_top
    import tmrctr_pkg::*;
(
    // Clock and power-on reset
    input  wire logic          I_CLOCK,
    input  wire logic          I_RST_B,
    // Register port
    input  wire logic [7:0]    I_ADDR,
    input  wire logic [7:0]    I_WDATA,
    input  wire logic          I_WR,
    input  wire logic          I_RD,
    output logic [7:0]         O_RDATA,
    // Core state and compare-unit triggers
    input  wire logic          I_SLEEP,
    input  wire logic          I_CMP1_TRIG,
    input  wire logic          I_CMP2_TRIG,
    // Oscillator input pin
    input  wire logic          I_OSC_IN_PIN,
    output logic               O_OSC_IN_PIN,
    output logic               O_OSC_IN_OE,
    // External clock pin
    input  wire logic          I_EXT_CLK_PIN,
    output logic               O_EXT_CLK_PIN,
    output logic               O_EXT_CLK_OE,
    // Port logic sharing the pins
    input  wire logic [1:0]    I_PORT_DIR,
    input  wire logic [1:0]    I_PORT_OUT,
    output logic [1:0]         O_PORT_RD,
    // Timebase and overflow
    output logic [15:0]        O_COUNT,
    output logic               O_TIMEBASE_VALID,
    output logic               O_IRQ,
    output logic               O_WAKE
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_meta;
    logic rst_b;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta <= 1'b0;
            rst_b    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    tmrctr_byte_t  control;
    tmrctr_count_t count;
    logic          flag;
    logic          irq_en;
    logic          ps_clr;
    logic [7:0]    rdata;

    logic on;
    logic cs;
    logic sync_byp;
    logic osc_en;
    tmrctr_prescale_e ps_sel;

    assign on       = control[`TMRCTR_BIT_ON];
    assign cs       = control[`TMRCTR_BIT_CS];
    assign sync_byp = control[`TMRCTR_BIT_SYNC_BYP];
    assign osc_en   = control[`TMRCTR_BIT_OSC_EN];
    assign ps_sel   = tmrctr_prescale_e'(control[`TMRCTR_BIT_PS_HI:`TMRCTR_BIT_PS_LO]);

    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_flag;
    logic wr_en;

    assign wr_low  = I_WR && (I_ADDR == `TMRCTR_OFS_COUNT_LOW);
    assign wr_high = I_WR && (I_ADDR == `TMRCTR_OFS_COUNT_HIGH);
    assign wr_ctrl = I_WR && (I_ADDR == `TMRCTR_OFS_CONTROL);
    assign wr_flag = I_WR && (I_ADDR == `TMRCTR_OFS_FLAG);
    assign wr_en   = I_WR && (I_ADDR == `TMRCTR_OFS_IRQ_EN);

    // Only power-on or brown-out reaches I_RST_B; other resets never touch
    // the control register.
    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            control <= `TMRCTR_CTRL_RESET;
        end else if (wr_ctrl) begin
            control <= I_WDATA & `TMRCTR_CTRL_MASK;
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            irq_en <= 1'b0;
        end else if (wr_en) begin
            irq_en <= I_WDATA[`TMRCTR_BIT_FLAG];
        end
    end

    // Held for one cycle after a count write; clears the ripple stages.
    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            ps_clr <= 1'b1;
        end else begin
            ps_clr <= wr_low || wr_high;
        end
    end

    // ------------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------------
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;

    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_meta <= {I_OSC_IN_PIN, I_EXT_CLK_PIN};
            pin_sync <= pin_meta;
        end
    end

    // With the oscillator on, both pins are inputs whatever the direction
    // bits say, and reads of them return zero.
    assign O_OSC_IN_PIN  = I_PORT_OUT[1];
    assign O_OSC_IN_OE   = !osc_en && !I_PORT_DIR[1];
    assign O_EXT_CLK_PIN = I_PORT_OUT[0];
    assign O_EXT_CLK_OE  = !osc_en && !I_PORT_DIR[0];
    assign O_PORT_RD     = osc_en ? 2'h0 : pin_sync;

    // ------------------------------------------------------------------------
    // Counter input path
    // ------------------------------------------------------------------------
    logic raw_edge_src;
    logic ps_out;
    logic ps_clr_any;

    assign raw_edge_src = osc_en ? I_OSC_IN_PIN : I_EXT_CLK_PIN;
    assign ps_clr_any   = ps_clr || !rst_b;

    tmrctr_ripple #(
        .STAGES (3)
    ) u_ripple (
        .i_raw  (raw_edge_src),
        .i_clr  (ps_clr_any),
        .i_sel  (ps_sel),
        .o_div  (ps_out)
    );

    // The prescaler output is brought into the core clock after division,
    // so the core clock only has to keep up with the divided rate.
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;

    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ps_out;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    logic ext_rise;

    // Synchronized mode stops while asleep; unsynchronized mode runs on.
    assign ext_rise = ext_sync && !ext_prev && (sync_byp || !I_SLEEP);

    // ------------------------------------------------------------------------
    // Timer mode prescaler
    // ------------------------------------------------------------------------
    logic [2:0] div_cnt;
    logic [2:0] div_mask;
    logic       int_tick;

    always_comb begin
        case (ps_sel)
            TMRCTR_DIV1: div_mask = 3'h0;
            TMRCTR_DIV2: div_mask = 3'h1;
            TMRCTR_DIV4: div_mask = 3'h3;
            TMRCTR_DIV8: div_mask = 3'h7;
            default:     div_mask = 3'h0;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 3'h0;
        end else if (wr_low || wr_high) begin
            div_cnt <= 3'h0;
        end else if (!cs && !I_SLEEP) begin
            div_cnt <= (div_cnt + 3'h1) & div_mask;
        end
    end

    // The instruction clock stops in sleep, so timer mode cannot advance.
    assign int_tick = !I_SLEEP && ((div_cnt & div_mask) == div_mask);

    // ------------------------------------------------------------------------
    // Count
    // ------------------------------------------------------------------------
    logic inc;
    logic evt_clr;
    logic wrap;

    assign inc     = on && (cs ? ext_rise : int_tick);
    // Unsynchronized mode drops the clear; it could not be made reliable.
    assign evt_clr = (I_CMP1_TRIG || I_CMP2_TRIG) && !(cs && sync_byp);
    assign wrap    = inc && (count == `TMRCTR_COUNT_MAX) && !evt_clr && !wr_low && !wr_high;

    // The count has no reset at all; only compare events and writes move it
    // besides counting. A write racing a running count is left to software.
    always_ff @(posedge I_CLOCK) begin
        if (wr_low || wr_high) begin
            if (wr_low) begin
                count[7:0] <= I_WDATA;
            end
            if (wr_high) begin
                count[15:8] <= I_WDATA;
            end
        end else if (evt_clr) begin
            count <= `TMRCTR_COUNT_ZERO;
        end else if (inc) begin
            count <= count + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (wrap) begin
            flag <= 1'b1;
        end else if (wr_flag) begin
            flag <= I_WDATA[`TMRCTR_BIT_FLAG];
        end
    end

    assign O_IRQ  = flag && irq_en;
    assign O_WAKE = flag && irq_en && cs && sync_byp;

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Reads come from the core-clock copy of the count, never from a
    // half-updated value.
    always_ff @(posedge I_CLOCK or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= `TMRCTR_READ_NONE;
        end else if (I_RD) begin
            case (I_ADDR)
                `TMRCTR_OFS_COUNT_LOW:  rdata <= count[7:0];
                `TMRCTR_OFS_COUNT_HIGH: rdata <= count[15:8];
                `TMRCTR_OFS_CONTROL:    rdata <= control;
                `TMRCTR_OFS_FLAG:       rdata <= {7'h00, flag};
                `TMRCTR_OFS_IRQ_EN:     rdata <= {7'h00, irq_en};
                default:                rdata <= `TMRCTR_READ_NONE;
            endcase
        end else begin
            rdata <= `TMRCTR_READ_NONE;
        end
    end

    assign O_RDATA          = rdata;
    assign O_COUNT          = count;
    assign O_TIMEBASE_VALID = !(cs && sync_byp);

endmodule

`default_nettype wire

// ---- shared/tmrctr_pkg.sv ----
// Types shared by the timer/counter design files.
// Assumes the register header is compiled alongside.
package tmrctr_pkg;

    typedef logic [7:0]  tmrctr_byte_t;
    typedef logic [15:0] tmrctr_count_t;

    typedef enum logic [1:0] {
        TMRCTR_DIV1 = 2'h0,
        TMRCTR_DIV2 = 2'h1,
        TMRCTR_DIV4 = 2'h2,
        TMRCTR_DIV8 = 2'h3
    } tmrctr_prescale_e;

endpackage

// ---- shared/tmrctr_regs.svh ----
// Register offsets, field positions and reset values of the 16-bit timer/counter.
// Assumes an 8-bit register bus with byte-wide registers.
`ifndef TMRCTR_REGS_SVH
`define TMRCTR_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define TMRCTR_OFS_COUNT_LOW   8'h0E
`define TMRCTR_OFS_COUNT_HIGH  8'h0F
`define TMRCTR_OFS_CONTROL     8'h10
`define TMRCTR_OFS_FLAG        8'h11
`define TMRCTR_OFS_IRQ_EN      8'h12

// ----------------------------------------------------------------------------
// Control fields, flag bit, read default and count limits
// ----------------------------------------------------------------------------
`define TMRCTR_BIT_ON          0
`define TMRCTR_BIT_CS          1
`define TMRCTR_BIT_SYNC_BYP    2
`define TMRCTR_BIT_OSC_EN      3
`define TMRCTR_BIT_PS_LO       4
`define TMRCTR_BIT_PS_HI       5
`define TMRCTR_CTRL_MASK       8'h3F
`define TMRCTR_CTRL_RESET      8'h00
`define TMRCTR_BIT_FLAG        0
`define TMRCTR_READ_NONE       8'h00
`define TMRCTR_COUNT_MAX       16'hFFFF
`define TMRCTR_COUNT_ZERO      16'h0000

`endif

// ---- verif/tmrctr_clk_src.sv ----
// Stand-in for the external clock source or low-power crystal.
// Assumes the bench calls burst() and resolves the pin levels itself.
`timescale 1ns/1ps
`default_nettype none

module tmrctr_clk_src #(
    parameter int HALF_NS = 50
) (
    input  wire logic i_to_osc,
    output logic      o_ext_clk,
    output logic      o_osc_clk
);
    logic clk = 1'b0;

    // The line rests low between bursts, like a gated-off crystal.
    assign o_osc_clk = i_to_osc & clk;
    assign o_ext_clk = ~i_to_osc & clk;

    task automatic burst(input int n);
        repeat (n) begin
            #HALF_NS clk = 1'b1;
            #HALF_NS clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/tmrctr_monitor.sv ----
// Concurrent checks on the ports of the timer/counter top.
// Assumes it is bound into the top module and sees the raw power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "tmrctr_regs.svh"

module tmrctr_monitor (
    // Clock, reset and register port
    input wire logic        I_CLOCK,
    input wire logic        I_RST_B,
    input wire logic [7:0]  I_ADDR,
    input wire logic [7:0]  I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [7:0]  O_RDATA,
    // Triggers, pins and timebase
    input wire logic        I_CMP1_TRIG,
    input wire logic        I_CMP2_TRIG,
    input wire logic        O_OSC_IN_OE,
    input wire logic        O_EXT_CLK_OE,
    input wire logic [1:0]  O_PORT_RD,
    input wire logic [15:0] O_COUNT,
    input wire logic        O_TIMEBASE_VALID,
    input wire logic        O_IRQ
);
    localparam logic [7:0] A_LO = `TMRCTR_OFS_COUNT_LOW, A_HI = `TMRCTR_OFS_COUNT_HIGH;
    localparam logic [7:0] A_CTL = `TMRCTR_OFS_CONTROL, A_IEN = `TMRCTR_OFS_IRQ_EN;
    logic       on_q, asy_q, en_q;
    logic [1:0] seen;
    logic [2:0] idle;
    wire logic  trig = I_CMP1_TRIG | I_CMP2_TRIG;
    wire logic  cwr  = I_WR && (I_ADDR == A_LO || I_ADDR == A_HI);

    // ------------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            on_q  <= 1'b0;
            asy_q <= 1'b0;
            en_q  <= 1'b0;
        end else if (I_WR && I_ADDR == A_CTL) begin
            on_q  <= I_WDATA[0];
            asy_q <= I_WDATA[1] & I_WDATA[2];
        end else if (I_WR && I_ADDR == A_IEN) begin
            en_q <= I_WDATA[0];
        end
    end

    // The count has no reset, so the hold check waits until both bytes were written.
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            seen <= 2'b00;
            idle <= 3'h0;
        end else begin
            seen <= seen | {cwr && I_ADDR == A_HI, cwr && I_ADDR == A_LO};
            idle <= (on_q || cwr || trig) ? 3'h0 : idle + {2'b00, idle != 3'h7};
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking dc @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);

    sequence s_ctl; I_WR && I_ADDR == A_CTL; endsequence
    sequence s_wrap; $past(O_COUNT) == 16'hFFFF && O_COUNT == 16'h0000 && !$past(trig) && !$past(cwr); endsequence
    property p_ctl_rsv; I_RD && I_ADDR == A_CTL |=> O_RDATA[7:6] == 2'b00; endproperty
    property p_step; !(I_WR || trig) ##1 $changed(O_COUNT) |-> O_COUNT == $past(O_COUNT) + 16'h0001; endproperty
    property p_hold; idle == 3'h7 && seen == 2'b11 |-> $stable(O_COUNT); endproperty
    property p_clr; trig && !cwr && !asy_q |=> O_COUNT == 16'h0000; endproperty
    property p_wr_lo; I_WR && I_ADDR == A_LO |=> O_COUNT[7:0] == $past(I_WDATA); endproperty
    property p_irq_on; s_wrap ##0 en_q |-> ##[0:1] O_IRQ; endproperty
    property p_irq_off; !en_q |-> !O_IRQ; endproperty
    property p_tbv; s_ctl |=> O_TIMEBASE_VALID == !asy_q; endproperty
    property p_pins; s_ctl ##0 I_WDATA[3] |=> !O_OSC_IN_OE && !O_EXT_CLK_OE && O_PORT_RD == 2'b00; endproperty

    a_ctl_rsv: assert property (p_ctl_rsv) else $error("control top bits read nonzero");
    a_step: assert property (p_step) else $error("count moved by other than one");
    a_hold: assert property (p_hold) else $error("stopped count moved");
    a_clr: assert property (p_clr) else $error("trigger did not clear count");
    a_wr_lo: assert property (p_wr_lo) else $error("low byte write lost");
    a_irq_on: assert property (p_irq_on) else $error("wrap gave no interrupt");
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
    a_tbv: assert property (p_tbv) else $error("timebase valid wrong for mode");
    a_pins: assert property (p_pins) else $error("pins not released to input");
endmodule

bind tmrctr_top tmrctr_monitor u_mon (
    .I_CLOCK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_CMP1_TRIG, .I_CMP2_TRIG,
    .O_OSC_IN_OE, .O_EXT_CLK_OE, .O_PORT_RD, .O_COUNT, .O_TIMEBASE_VALID, .O_IRQ
);
`default_nettype wire

// ---- verif/tmrctr_tb.sv ----
// Self-checking bench for the 16-bit timer/counter.
// Assumes the monitor and the clock source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tmrctr_regs.svh"

module tmrctr_tb;
    localparam logic [7:0] A_LO = `TMRCTR_OFS_COUNT_LOW, A_HI = `TMRCTR_OFS_COUNT_HIGH;
    localparam logic [7:0] A_CTL = `TMRCTR_OFS_CONTROL, A_FLG = `TMRCTR_OFS_FLAG, A_IEN = `TMRCTR_OFS_IRQ_EN;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, slp = 1'b0, osc_sel = 1'b0;
    logic [1:0]  trig = 2'b00, dir = 2'b00, port_rd;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] count, snap;
    logic        osc_o, osc_oe, ext_o, ext_oe, tbv, irq, wake, ext_src, osc_src;
    int          errors = 0, n_tests = 0;
    wire logic   ext_pin = ext_oe ? ext_o : ext_src;
    wire logic   osc_pin = osc_oe ? osc_o : osc_src;

    always #10 clk = ~clk;

    tmrctr_top dut (
        .I_CLOCK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_SLEEP(slp), .I_CMP1_TRIG(trig[0]), .I_CMP2_TRIG(trig[1]),
        .I_OSC_IN_PIN(osc_pin), .O_OSC_IN_PIN(osc_o), .O_OSC_IN_OE(osc_oe),
        .I_EXT_CLK_PIN(ext_pin), .O_EXT_CLK_PIN(ext_o), .O_EXT_CLK_OE(ext_oe),
        .I_PORT_DIR(dir), .I_PORT_OUT(2'b01), .O_PORT_RD(port_rd), .O_COUNT(count),
        .O_TIMEBASE_VALID(tbv), .O_IRQ(irq), .O_WAKE(wake)
    );

    tmrctr_clk_src src (.i_to_osc(osc_sel), .o_ext_clk(ext_src), .o_osc_clk(osc_src));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrt(input logic [7:0] a, input logic [7:0] d, input logic [1:0] t);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        trig  <= t;
        @(posedge clk);
        wr    <= 1'b0;
        trig  <= 2'b00;
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wrt(a, d, 2'b00);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        tick(3);
    endtask

    task automatic done(input string s);
        $display("test %s finished, %0d mismatches so far", s, errors);
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        errors++;
        final_report();
    end

    initial begin
        do_reset();
        rd_chk(A_CTL, 8'h00);
        chk({15'h0, ext_oe}, 16'h0001);
        chk({14'h0, port_rd}, 16'h0001);
        wr_reg(A_CTL, 8'hFF);
        rd_chk(A_CTL, 8'h3F);
        chk({12'h0, ext_oe, osc_oe, port_rd}, 16'h0000);
        wr_reg(A_CTL, 8'h00);
        rd_chk(8'h20, 8'h00);
        @(posedge clk) dir <= 2'b11;
        done("registers");
        // The count is written only while stopped; a racing write is unpredictable.
        wr_reg(A_LO, 8'hFE);
        wr_reg(A_HI, 8'hFF);
        rd_chk(A_LO, 8'hFE);
        rd_chk(A_HI, 8'hFF);
        wr_reg(A_IEN, 8'h01);
        wr_reg(A_CTL, 8'h01);
        tick(4);
        wr_reg(A_CTL, 8'h00);
        chk({15'h0, count < 16'h0010}, 16'h0001);
        rd_chk(A_FLG, 8'h01);
        chk({15'h0, irq}, 16'h0001);
        snap = count;
        tick(6);
        chk(count, snap);
        wr_reg(A_IEN, 8'h00);
        chk({15'h0, irq}, 16'h0000);
        wr_reg(A_FLG, 8'h00);
        rd_chk(A_FLG, 8'h00);
        done("overflow");
        for (int p = 0; p < 4; p++) begin
            wr_reg(A_CTL, {2'b00, p[1:0], 4'h1});
            tick(3);
            snap = count;
            tick(8);
            chk(count - snap, 16'(8 >> p));
        end
        wr_reg(A_CTL, 8'h00);
        done("prescale");
        for (int t = 1; t < 3; t++) begin
            wr_reg(A_HI, 8'h12);
            wr_reg(A_LO, 8'h34);
            wrt(8'h20, 8'h00, t[1:0]);
            chk(count, 16'h0000);
            rd_chk(A_FLG, 8'h00);
        end
        wrt(A_LO, 8'h56, 2'b10);
        chk(count, 16'h0056);
        wr_reg(A_CTL, 8'h30);
        do_reset();
        chk(count, 16'h0056);
        rd_chk(A_CTL, 8'h00);
        done("trigger and reset");
        for (int m = 0; m < 2; m++) begin
            osc_sel = m[0];
            wr_reg(A_CTL, m[0] ? 8'h0B : 8'h03);
            snap = count;
            src.burst(5);
            tick(8);
            chk(count - snap, 16'h0005);
        end
        snap = count;
        @(posedge clk) slp <= 1'b1;
        src.burst(4);
        tick(8);
        chk(count, snap);
        wr_reg(A_CTL, 8'h00);
        wr_reg(A_LO, 8'hFE);
        wr_reg(A_HI, 8'hFF);
        wr_reg(A_IEN, 8'h01);
        wr_reg(A_CTL, 8'h0F);
        chk({15'h0, tbv}, 16'h0000);
        src.burst(4);
        tick(8);
        chk(count, 16'h0002);
        chk({15'h0, wake}, 16'h0001);
        @(posedge clk) slp <= 1'b0;
        wr_reg(A_CTL, 8'h05);
        chk({15'h0, tbv}, 16'h0001);
        // Three edges leave the divide-by-4 ripple output high, three edges short of its next rise; a
        // count write must drop that progress, so two more edges give one count.
        osc_sel = 1'b0;
        wr_reg(A_CTL, 8'h22);
        src.burst(3);
        wr_reg(A_LO, 8'h00);
        wr_reg(A_HI, 8'h00);
        wr_reg(A_CTL, 8'h23);
        src.burst(2);
        tick(8);
        chk(count, 16'h0001);
        done("counter");
        final_report();
    end
endmodule
`default_nettype wire
